/* File: rtl/thfan_defs.svh */
`ifndef THFAN_DEFS_SVH
`define THFAN_DEFS_SVH

// register placement and reset value
`define THFAN_STATUS_ADDR    8'h02
`define THFAN_STATUS_RESET   8'h00
`define THFAN_UNMAPPED_DATA  8'h00

// field positions inside the alarm status register
`define THFAN_BIT_LOCAL_LOW   7
`define THFAN_BIT_LOCAL_HIGH  6
`define THFAN_BIT_SENS_FAULT  5
`define THFAN_BIT_SHUTDOWN    4
`define THFAN_BIT_REMOTE_LOW  3
`define THFAN_BIT_REMOTE_HIGH 2
`define THFAN_BIT_FAN_SLOW    1
`define THFAN_BIT_OVERSPEED   0

// every bit except the sensor fault one is cleared by a read
`define THFAN_READ_CLEAR_MASK 8'hdf

// remote result substituted on a sensor fault (minus 128 degrees)
`define THFAN_FAULT_TEMP      8'h80

// shutdown re-arm hysteresis in degrees
`define THFAN_SHUT_HYST       9'h005

// consecutive slow detections that make a fan failure
`define THFAN_FAN_FAIL_COUNT  3'h5

`endif

/* File: rtl/thfan_pkg.sv */
package thfan_pkg;
   // signed two's complement temperature in whole degrees
   typedef logic signed [7:0] thfan_temp_t;
   // alarm status register image
   typedef logic [7:0]        thfan_status_t;
   // register address on the management bus
   typedef logic [7:0]        thfan_addr_t;
endpackage

/* File: rtl/thfan_flag_cell.sv */
`timescale 1ns/10ps
`default_nettype none
module thfan_flag_cell #(
   parameter bit REARM = 1'b0
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic ce,
   input  wire logic tick,
   input  wire logic cond,
   input  wire logic rearm_cond,
   input  wire logic force_set,
   input  wire logic clr,
   output logic      flag,
   output logic      armed
);
   logic set_w;

   // a set needs a monitoring tick, the condition and an armed cell, or force_set alone
   assign set_w = (tick & cond & armed) | force_set;

   // sticky flag, the set wins over a clearing read in the same cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         flag <= 1'b0;
      end else if (ce) begin
         if (set_w) begin
            flag <= 1'b1;
         end else if (clr) begin
            flag <= 1'b0;
         end
      end
   end

   // re-arm gate: a read that clears a set flag disarms it until rearm_cond;
   // a re-arm tick in that same cycle wins, the condition has already passed
   always_ff @(posedge clk) begin
      if (rst) begin
         armed <= 1'b1;
      end else if (ce) begin
         if (!REARM) begin
            armed <= 1'b1;
         end else if (tick && rearm_cond) begin
            armed <= 1'b1;
         end else if (clr && flag && !set_w) begin
            armed <= 1'b0;
         end
      end
   end

   a_cell_set_wins : assert property (@(posedge clk) disable iff (rst)
      ce && set_w |=> flag)
      else $error("flag cell lost a set event");
   a_cell_disarm : assert property (@(posedge clk) disable iff (rst)
      REARM && ce && clr && flag && !set_w |=> !flag && (armed == $past(tick && rearm_cond)))
      else $error("flag cell did not disarm after a clearing read");
endmodule
`default_nettype wire

/* File: rtl/thfan_alarm_status.sv */
// Summary of operation
// - flags are sticky; all but bit 5 cleared by reading
// - persisting conditions on bits 7, 6, 3, 2 and 1 set again next monitoring cycle
// - eight-bit register at 0x02, resets to 0x00
// - bit 7 set when local at/below low
// - bit 6 set when local at/above high
// - bit 5 sensor fault, over-limit, result -128
// - sensor fault survives reads until reset
// - sensor fault alerts when its enable set
// - bit 4 shutdown limit, pin low, alert
// - shutdown re-arms only 5 degrees below limit
// - bit 3 set when remote at/below low
// - bit 2 set when remote at/above high
// - bit 1 set when period at/above limit
// - no slow check during fan spin-up
// - spin-up end sets slow flag until read
// - five consecutive slow detections drive fault low
// - slow flag alerts when fan enable set
// - bit 0 set when period at/below limit
// - overspeed re-arms only after speed falls
// - overspeed alerts but never drives fan fault
`timescale 1ns/10ps
`default_nettype none
`include "thfan_defs.svh"
module thfan_alarm_status #(
   parameter int FAN_PERIOD_COUNT_W = 16
) (
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire logic                ce,
   input  wire logic                soft_rst,
   input  wire logic                mon_tick,
   input  wire thfan_pkg::thfan_temp_t local_temp,
   input  wire thfan_pkg::thfan_temp_t remote_temp,
   input  wire thfan_pkg::thfan_temp_t local_low_lim,
   input  wire thfan_pkg::thfan_temp_t local_high_lim,
   input  wire thfan_pkg::thfan_temp_t remote_low_lim,
   input  wire thfan_pkg::thfan_temp_t remote_high_lim,
   input  wire thfan_pkg::thfan_temp_t remote_shutdown_lim,
   input  wire logic                remote_sensor_bad,
   input  wire logic [FAN_PERIOD_COUNT_W-1:0]   fan_period_count,
   input  wire logic [FAN_PERIOD_COUNT_W-1:0]   fan_low_count_lim,
   input  wire logic [FAN_PERIOD_COUNT_W-1:0]   fan_high_count_lim,
   input  wire logic                fan_spinning_up,
   input  wire logic                sensor_fault_irq_en,
   input  wire logic                shutdown_irq_en,
   input  wire logic                fan_range_irq_en,
   input  wire logic                rd_en,
   input  wire thfan_pkg::thfan_addr_t rd_addr,
   output thfan_pkg::thfan_status_t rd_data,
   output logic                     rd_valid,
   output thfan_pkg::thfan_temp_t   remote_temp_result,
   output logic                     over_limit_out_n,
   output logic                     shutdown_pin_n,
   output logic                     alert_n,
   output logic                     fan_fault_n
);
   import thfan_pkg::*;

   // power-on and software reset act alike on every flop
   logic          rst_all;
   logic          rd_hit;
   logic          spin_q;
   logic          spin_done;
   logic          slow_eval;
   logic          local_low_cond;
   logic          local_high_cond;
   logic          remote_low_cond;
   logic          remote_high_cond;
   logic          shut_cond;
   logic          shut_rearm_cond;
   logic          slow_cond;
   logic          over_cond;
   logic          over_rearm_cond;
   logic signed [8:0] shut_rearm_lim;
   logic          local_low_flag;
   logic          local_high_flag;
   logic          remote_sensor_fault_flag;
   logic          remote_shutdown_limit_flag;
   logic          remote_low_flag;
   logic          remote_high_flag;
   logic          fan_slow_flag;
   logic          fan_overspeed_flag;
   logic          shut_armed;
   logic          over_armed;
   logic [2:0]    slow_run_q;
   logic          fan_fail_q;
   thfan_status_t status_w;

   assign rst_all = rst | soft_rst;

   // a read of the status address is the clearing event
   assign rd_hit = rd_en && (rd_addr == `THFAN_STATUS_ADDR);

   // spin-up tracking: its falling edge marks the end of spin-up
   always_ff @(posedge clk) begin
      if (rst_all) begin
         spin_q <= 1'b0;
      end else if (ce) begin
         spin_q <= fan_spinning_up;
      end
   end
   assign spin_done = spin_q & ~fan_spinning_up;
   assign slow_eval = ~fan_spinning_up;

   // limit comparisons, signed for temperatures and unsigned for counts
   assign local_low_cond   = local_temp <= local_low_lim;
   assign local_high_cond  = local_temp >= local_high_lim;
   assign remote_low_cond  = remote_temp <= remote_low_lim;
   assign remote_high_cond = remote_temp >= remote_high_lim;
   assign shut_cond        = remote_temp > remote_shutdown_lim;
   assign shut_rearm_lim   = 9'(signed'({remote_shutdown_lim[7], remote_shutdown_lim})
                             - signed'(`THFAN_SHUT_HYST));
   assign shut_rearm_cond  = signed'({remote_temp[7], remote_temp}) <= shut_rearm_lim;
   assign slow_cond        = slow_eval && (fan_period_count >= fan_low_count_lim);
   assign over_cond        = fan_period_count <= fan_high_count_lim;
   assign over_rearm_cond  = fan_period_count > fan_high_count_lim;

   // flags that re-set on every monitoring cycle while the condition holds
   thfan_flag_cell #(.REARM(1'b0)) u_local_low (
      .clk(clk), .rst(rst_all), .ce(ce), .tick(mon_tick), .cond(local_low_cond),
      .rearm_cond(1'b1), .force_set(1'b0), .clr(rd_hit),
      .flag(local_low_flag), .armed()
   );
   thfan_flag_cell #(.REARM(1'b0)) u_local_high (
      .clk(clk), .rst(rst_all), .ce(ce), .tick(mon_tick), .cond(local_high_cond),
      .rearm_cond(1'b1), .force_set(1'b0), .clr(rd_hit),
      .flag(local_high_flag), .armed()
   );
   thfan_flag_cell #(.REARM(1'b0)) u_remote_low (
      .clk(clk), .rst(rst_all), .ce(ce), .tick(mon_tick), .cond(remote_low_cond),
      .rearm_cond(1'b1), .force_set(1'b0), .clr(rd_hit),
      .flag(remote_low_flag), .armed()
   );
   thfan_flag_cell #(.REARM(1'b0)) u_remote_high (
      .clk(clk), .rst(rst_all), .ce(ce), .tick(mon_tick), .cond(remote_high_cond),
      .rearm_cond(1'b1), .force_set(1'b0), .clr(rd_hit),
      .flag(remote_high_flag), .armed()
   );

   // slow flag is also forced on at the end of spin-up
   thfan_flag_cell #(.REARM(1'b0)) u_fan_slow (
      .clk(clk), .rst(rst_all), .ce(ce), .tick(mon_tick), .cond(slow_cond),
      .rearm_cond(1'b1), .force_set(spin_done), .clr(rd_hit),
      .flag(fan_slow_flag), .armed()
   );

   // flags with their own re-arm gate after a clearing read
   thfan_flag_cell #(.REARM(1'b1)) u_shutdown (
      .clk(clk), .rst(rst_all), .ce(ce), .tick(mon_tick), .cond(shut_cond),
      .rearm_cond(shut_rearm_cond), .force_set(1'b0), .clr(rd_hit),
      .flag(remote_shutdown_limit_flag), .armed(shut_armed)
   );
   thfan_flag_cell #(.REARM(1'b1)) u_overspeed (
      .clk(clk), .rst(rst_all), .ce(ce), .tick(mon_tick), .cond(over_cond),
      .rearm_cond(over_rearm_cond), .force_set(1'b0), .clr(rd_hit),
      .flag(fan_overspeed_flag), .armed(over_armed)
   );

   // sensor fault latches on any cycle and only a reset clears it
   always_ff @(posedge clk) begin
      if (rst_all) begin
         remote_sensor_fault_flag <= 1'b0;
      end else if (ce && remote_sensor_bad) begin
         remote_sensor_fault_flag <= 1'b1;
      end
   end

   // consecutive slow detections per monitoring cycle, saturating
   always_ff @(posedge clk) begin
      if (rst_all) begin
         slow_run_q <= 3'h0;
      end else if (ce && mon_tick && slow_eval) begin
         if (!slow_cond) begin
            slow_run_q <= 3'h0;
         end else if (slow_run_q != `THFAN_FAN_FAIL_COUNT) begin
            slow_run_q <= slow_run_q + 3'h1;
         end
      end
   end

   // fan failure state follows the run counter reaching its limit
   always_ff @(posedge clk) begin
      if (rst_all) begin
         fan_fail_q <= 1'b0;
      end else if (ce && mon_tick && slow_eval) begin
         fan_fail_q <= slow_cond && (slow_run_q >= `THFAN_FAN_FAIL_COUNT - 3'h1);
      end
   end

   // register image, bit positions fixed by the header
   always_comb begin
      status_w                             = `THFAN_STATUS_RESET;
      status_w[`THFAN_BIT_LOCAL_LOW]       = local_low_flag;
      status_w[`THFAN_BIT_LOCAL_HIGH]      = local_high_flag;
      status_w[`THFAN_BIT_SENS_FAULT]      = remote_sensor_fault_flag;
      status_w[`THFAN_BIT_SHUTDOWN]        = remote_shutdown_limit_flag;
      status_w[`THFAN_BIT_REMOTE_LOW]      = remote_low_flag;
      status_w[`THFAN_BIT_REMOTE_HIGH]     = remote_high_flag;
      status_w[`THFAN_BIT_FAN_SLOW]        = fan_slow_flag;
      status_w[`THFAN_BIT_OVERSPEED]       = fan_overspeed_flag;
   end

   // read port: data captured before the clear takes effect
   always_ff @(posedge clk) begin
      if (rst_all) begin
         rd_data  <= `THFAN_STATUS_RESET;
         rd_valid <= 1'b0;
      end else if (ce) begin
         rd_valid <= rd_en;
         if (rd_hit) begin
            rd_data <= status_w;
         end else if (rd_en) begin
            rd_data <= `THFAN_UNMAPPED_DATA;
         end
      end
   end

   // remote result forced to minus 128 while the sensor is faulted
   always_ff @(posedge clk) begin
      if (rst_all) begin
         remote_temp_result <= 8'sh00;
      end else if (ce) begin
         remote_temp_result <= remote_sensor_fault_flag ? `THFAN_FAULT_TEMP : remote_temp;
      end
   end

   // active low pins driven from flags
   always_ff @(posedge clk) begin
      if (rst_all) begin
         over_limit_out_n <= 1'b1;
         shutdown_pin_n   <= 1'b1;
         fan_fault_n      <= 1'b1;
      end else if (ce) begin
         over_limit_out_n <= ~remote_sensor_fault_flag;
         shutdown_pin_n   <= ~remote_shutdown_limit_flag;
         fan_fault_n      <= ~fan_fail_q;
      end
   end

   // bus alert collects the enabled alarm sources
   always_ff @(posedge clk) begin
      if (rst_all) begin
         alert_n <= 1'b1;
      end else if (ce) begin
         alert_n <= ~((remote_sensor_fault_flag & sensor_fault_irq_en)
                   | (remote_shutdown_limit_flag & shutdown_irq_en)
                   | ((fan_slow_flag | fan_overspeed_flag) & fan_range_irq_en));
      end
   end

   // checks, all on the single clock
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst_all);

   a_reset_reads_zero : assert property (@(posedge clk) disable iff (1'b0)
      rst_all |=> (status_w == `THFAN_STATUS_RESET) && !rd_valid)
      else $error("status not zero after reset");
   a_read_clears_all : assert property (
      ce && rd_hit && !mon_tick && !spin_done
      |=> (status_w & `THFAN_READ_CLEAR_MASK) == 8'h00)
      else $error("read did not clear the status flags");
   a_read_returns_image : assert property (
      ce && rd_hit |=> rd_valid && rd_data == $past(status_w))
      else $error("read data differs from register image");
   a_persist_resets : assert property (
      ce && mon_tick && local_high_cond |=> local_high_flag)
      else $error("persisting high condition not set again");
   a_set_beats_clear : assert property (
      ce && rd_hit && mon_tick && local_low_cond |=> local_low_flag)
      else $error("set lost against clearing read");
   a_remote_limits : assert property (
      ce && mon_tick && remote_low_cond && remote_high_cond
      |=> remote_low_flag && remote_high_flag)
      else $error("remote limit flags not set");
   a_fault_survives_read : assert property (
      remote_sensor_fault_flag |=> remote_sensor_fault_flag)
      else $error("sensor fault flag cleared without reset");
   a_fault_forces_temp : assert property (
      ce && remote_sensor_fault_flag
      |=> remote_temp_result == `THFAN_FAULT_TEMP && !over_limit_out_n)
      else $error("sensor fault did not force result and pin");
   a_fault_alert : assert property (
      ce && remote_sensor_fault_flag && sensor_fault_irq_en |=> !alert_n)
      else $error("sensor fault alert missing");
   a_shutdown_pin_low : assert property (
      ce && remote_shutdown_limit_flag && shutdown_irq_en |=> !shutdown_pin_n && !alert_n)
      else $error("shutdown pin or alert not asserted");
   a_shutdown_stays_off : assert property (
      ce && !shut_armed && !remote_shutdown_limit_flag |=> !remote_shutdown_limit_flag)
      else $error("shutdown flag set while disarmed");
   a_shutdown_rearm : assert property (
      ce && mon_tick && shut_rearm_cond |=> shut_armed)
      else $error("shutdown flag not re-armed below hysteresis");
   a_no_slow_spinup : assert property (
      ce && fan_spinning_up && mon_tick && !fan_slow_flag && !spin_done
      |=> !fan_slow_flag)
      else $error("slow flag set during spin-up");
   a_spinup_end_slow : assert property (
      ce && spin_done |=> fan_slow_flag)
      else $error("slow flag not set after spin-up");
   a_fan_fail_five : assert property (
      ce && mon_tick && slow_cond && slow_run_q == 3'h4 |=> fan_fail_q ##1 !fan_fault_n)
      else $error("fan failure missing after five slow detections");
   a_fan_fail_early : assert property (
      ce && mon_tick && slow_eval && slow_run_q < 3'h4 |=> !fan_fail_q)
      else $error("fan failure before five slow detections");
   a_fan_alert : assert property (
      ce && (fan_slow_flag || fan_overspeed_flag) && fan_range_irq_en |=> !alert_n)
      else $error("fan range alert missing");
   a_overspeed_set : assert property (
      ce && mon_tick && over_cond && over_armed |=> fan_overspeed_flag)
      else $error("overspeed flag not set");
   a_overspeed_hold_off : assert property (
      ce && !over_armed && !fan_overspeed_flag |=> !fan_overspeed_flag)
      else $error("overspeed flag set again while still fast");
   a_overspeed_no_fault : assert property (
      ce && fan_overspeed_flag && !fan_fail_q |=> fan_fault_n)
      else $error("overspeed drove the fan fault pin");

   // set, clear and re-arm paths, idle pins and the unmapped read answer
   a_unmapped_read : assert property (
      ce && rd_en && !rd_hit |=> rd_valid && rd_data == `THFAN_UNMAPPED_DATA)
      else $error("unmapped read did not return zero");
   a_fault_latch : assert property (
      ce && remote_sensor_bad |=> remote_sensor_fault_flag)
      else $error("sensor fault not latched");
   a_shutdown_set : assert property (
      ce && mon_tick && shut_cond && shut_armed |=> remote_shutdown_limit_flag)
      else $error("shutdown flag not set above limit");
   a_shutdown_pin_idle : assert property (
      ce && !remote_shutdown_limit_flag |=> shutdown_pin_n)
      else $error("shutdown pin low without its flag");
   a_slow_set : assert property (
      ce && mon_tick && slow_cond |=> fan_slow_flag)
      else $error("slow flag not set on slow fan");
   a_slow_run_clear : assert property (
      ce && mon_tick && slow_eval && !slow_cond |=> slow_run_q == 3'h0 && !fan_fail_q)
      else $error("slow run not cleared by a good tick");
   a_overspeed_rearm : assert property (
      ce && mon_tick && over_rearm_cond |=> over_armed)
      else $error("overspeed not re-armed after slowing");
   a_alert_idle : assert property (
      ce && !remote_sensor_fault_flag && !remote_shutdown_limit_flag
      && !fan_slow_flag && !fan_overspeed_flag |=> alert_n)
      else $error("alert raised with no enabled source");

   c_read_while_set : cover property (ce && rd_hit && status_w != 8'h00);
   c_set_with_read : cover property (ce && rd_hit && mon_tick);
   c_fan_failure : cover property (ce && fan_fail_q && !fan_fault_n);
   c_shutdown_rearm : cover property (!shut_armed ##[1:50] shut_armed);
   c_overspeed_rearm : cover property (!over_armed ##[1:50] over_armed);
endmodule
`default_nettype wire

/* File: bench/thfan_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module thfan_host_model (
   input  wire logic                clk,
   input  wire logic                rd_valid,
   input  wire thfan_pkg::thfan_status_t rd_data,
   output logic                     rd_en,
   output thfan_pkg::thfan_addr_t   rd_addr
);
   import thfan_pkg::*;
   // one read: strobe held over one taken edge, then a bounded wait for the answer
   task automatic read_reg(input thfan_addr_t a, output thfan_status_t d, output bit ok);
      int n;
      ok = 1'b0;
      d = 8'h00;
      @(posedge clk);
      rd_en   <= 1'b1;
      rd_addr <= a;
      @(posedge clk);
      rd_en   <= 1'b0;
      rd_addr <= ~a; // released address shows a changed pattern
      for (n = 0; n < 4 && !ok; n++) begin
         #1;
         if (rd_valid === 1'b1) begin
            d  = rd_data;
            ok = 1'b1;
         end else begin
            @(posedge clk);
         end
      end
   endtask
   // bus idle at time zero
   initial begin
      rd_en   = 1'b0;
      rd_addr = 8'h00;
   end
endmodule
`default_nettype wire

/* File: bench/thermal_fan_alarm_status_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module thermal_fan_alarm_status_bench;
   import thfan_pkg::*;
   logic          clk = 1'b0, rst = 1'b1, ce = 1'b1, soft_rst = 1'b0, mon_tick = 1'b0;
   logic          sens_bad, spin_up, sf_en = 1'b0, sh_en = 1'b0, fan_en = 1'b0;
   logic          rd_en, rd_valid, lim_n, shut_n, alert_n, ffail_n;
   thfan_temp_t   l_t, r_t, l_lo, l_hi, r_lo, r_hi, r_sh, r_res;
   logic [15:0]   per, per_lo, per_hi;
   thfan_addr_t   rd_addr;
   thfan_status_t rd_data, got, img;
   thfan_temp_t   sh_seq [6] = '{8'h3c, 8'h3c, 8'h2e, 8'h3c, 8'h2d, 8'h3c};
   bit            ok;
   int            miscompares = 0, comparisons = 0, i, k;

   // 250 MHz clock
   always #2 clk = ~clk;

   thfan_alarm_status #(.FAN_PERIOD_COUNT_W(16)) dut_u (.clk(clk), .rst(rst), .ce(ce),
      .soft_rst(soft_rst), .mon_tick(mon_tick), .local_temp(l_t), .remote_temp(r_t),
      .local_low_lim(l_lo), .local_high_lim(l_hi), .remote_low_lim(r_lo),
      .remote_high_lim(r_hi), .remote_shutdown_lim(r_sh), .remote_sensor_bad(sens_bad),
      .fan_period_count(per), .fan_low_count_lim(per_lo), .fan_high_count_lim(per_hi),
      .fan_spinning_up(spin_up), .sensor_fault_irq_en(sf_en), .shutdown_irq_en(sh_en),
      .fan_range_irq_en(fan_en), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
      .rd_valid(rd_valid), .remote_temp_result(r_res), .over_limit_out_n(lim_n),
      .shutdown_pin_n(shut_n), .alert_n(alert_n), .fan_fault_n(ffail_n));

   thfan_host_model host_u (.clk(clk), .rd_valid(rd_valid), .rd_data(rd_data),
      .rd_en(rd_en), .rd_addr(rd_addr));

   // verdict and end of run
   task automatic give_verdict;
      $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // single comparison point
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // register read through the host model; a lost answer ends the run
   task automatic rd(input thfan_addr_t a);
      host_u.read_reg(a, got, ok);
      if (!ok) begin
         miscompares++;
         give_verdict();
      end
   endtask

   // one monitoring pulse, then time for flags and pins to settle
   task automatic tick;
      @(posedge clk);
      mon_tick <= 1'b1;
      @(posedge clk);
      mon_tick <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   // software reset held over one edge
   task automatic sreset;
      @(posedge clk);
      soft_rst <= 1'b1;
      @(posedge clk);
      soft_rst <= 1'b0;
   endtask

   // quiet operating point: no condition true
   task automatic neutral;
      l_t      <= 8'h00;
      r_t      <= 8'h00;
      l_lo     <= 8'hce;
      l_hi     <= 8'h32;
      r_lo     <= 8'hce;
      r_hi     <= 8'h32;
      r_sh     <= 8'h64;
      per      <= 16'h0064;
      per_lo   <= 16'h00c8;
      per_hi   <= 16'h000a;
      sens_bad <= 1'b0;
      spin_up  <= 1'b0;
   endtask

   // expected flag image from the present inputs
   function automatic thfan_status_t cond_img();
      return {l_t <= l_lo, l_t >= l_hi, 1'b0, r_t > r_sh, r_t <= r_lo, r_t >= r_hi,
              per >= per_lo, per <= per_hi};
   endfunction

   // small signed value so that limits are often met exactly
   function automatic thfan_temp_t rnd_t();
      return thfan_temp_t'(8'($urandom_range(0, 12)) - 8'h06);
   endfunction

   // watchdog against a hang
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      give_verdict();
   end

   // main sequence
   initial begin
      neutral();
      k = $urandom(32'hf599199f);
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rd(8'h02);
      check(got, 8'h00);
      l_t <= 8'h3c;
      tick();
      rd(8'h03);
      check(got, 8'h00);
      rd(8'h02);
      check(got, 8'h40);
      // sensor fault latches and survives reads
      neutral();
      sens_bad <= 1'b1;
      sf_en    <= 1'b1;
      repeat (2) @(posedge clk);
      sens_bad <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      check(8'({lim_n, alert_n}), 8'h00);
      check(r_res, 8'h80);
      for (k = 0; k < 2; k++) begin
         rd(8'h02);
         check(got, 8'h20);
      end
      sf_en <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      check(8'(alert_n), 8'h01);
      sreset();
      rd(8'h02);
      check(got, 8'h00);
      // shutdown flag re-arms only at limit minus five
      neutral();
      sh_en <= 1'b1;
      r_sh  <= 8'h32;
      for (k = 0; k < 6; k++) begin
         r_t <= sh_seq[k];
         tick();
         if (k == 0) check(8'({shut_n, alert_n}), 8'h00);
         rd(8'h02);
         check(8'(got[4]), 8'(k == 0 || k == 5));
      end
      // spin-up: no slow check, forced flag at the end
      sreset();
      neutral();
      fan_en  <= 1'b1;
      spin_up <= 1'b1;
      per     <= 16'h012c;
      tick();
      rd(8'h02);
      check(8'(got[1]), 8'h00);
      per     <= 16'h0064;
      spin_up <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      check(8'(alert_n), 8'h00);
      rd(8'h02);
      check(8'(got[1]), 8'h01);
      // five slow detections in a row make a fan failure
      sreset();
      per <= 16'h012c;
      for (k = 0; k < 5; k++) begin
         tick();
         if (k >= 3) check(8'(ffail_n), 8'(k == 3));
      end
      // a set arriving with the clearing read is kept
      sreset();
      neutral();
      l_t <= 8'h3c;
      fork
         rd(8'h02);
         begin
            @(posedge clk);
            mon_tick <= 1'b1;
            @(posedge clk);
            mon_tick <= 1'b0;
         end
      join
      l_t <= 8'h00;
      rd(8'h02);
      check(got, 8'h40);
      // clock enable low freezes state: a tick while frozen is not taken
      l_t <= 8'h3c;
      ce  <= 1'b0;
      tick();
      ce  <= 1'b1;
      rd(8'h02);
      check(got, 8'h00);
      tick();
      rd(8'h02);
      check(got, 8'h40);
      // random conditions: set, clear by read, set again where allowed
      for (i = 0; i < 24; i++) begin
         sreset();
         l_t    <= rnd_t();
         r_t    <= rnd_t();
         l_lo   <= rnd_t();
         l_hi   <= rnd_t();
         r_lo   <= rnd_t();
         r_hi   <= rnd_t();
         r_sh   <= rnd_t();
         per    <= 16'($urandom_range(0, 7));
         per_lo <= 16'($urandom_range(0, 7));
         per_hi <= 16'($urandom_range(0, 7));
         {sf_en, sh_en, fan_en} <= 3'($urandom);
         tick();
         img = cond_img();
         check(8'({alert_n, shut_n, ffail_n, lim_n}),
               8'({!((fan_en & (img[1] | img[0])) | (sh_en & img[4])), !img[4], 2'b11}));
         rd(8'h02);
         check(got, img);
         rd(8'h02);
         check(got, 8'h00);
         tick();
         rd(8'h02);
         check(got, img & 8'hee);
      end
      give_verdict();
   end
endmodule
`default_nettype wire
